// *** shared/gauge_cfg_pkg.sv ***
// package for the gauge configuration block: storage map, option
// fields, reset values and the structs that carry its ports.
// assumes byte-wide storage, high byte of a word at the lower address.
package gauge_cfg_pkg;

    // ==========================================================
    // storage map
    localparam int         MEM_DEPTH   = 216;
    localparam logic [8:0] MEM_TOP     = 9'h0d8;
    localparam logic [8:0] CAP_ALARM   = 9'h000;
    localparam logic [8:0] TIME_ALARM  = 9'h002;
    localparam logic [8:0] DESIGN_VOLT = 9'h004;
    localparam logic [8:0] CYCLE_INIT  = 9'h00c;
    localparam logic [8:0] PACK_OPT    = 9'h028;
    localparam logic [8:0] FILTER_THR  = 9'h02c;
    localparam logic [8:0] DESIGN_CAP  = 9'h032;
    localparam logic [8:0] FULL_CAP    = 9'h036;
    localparam logic [8:0] CYCLE_THR   = 9'h037;
    localparam logic [8:0] CHG_EFF     = 9'h054;
    localparam logic [8:0] SENSE_GAIN  = 9'h0cb;
    localparam logic [8:0] CC_DELTA    = 9'h0cd;
    localparam logic [8:0] CC_OFS      = 9'h0d2;
    localparam logic [8:0] DSC_OFS     = 9'h0d4;
    localparam logic [8:0] ADC_OFS     = 9'h0d5;
    localparam logic [8:0] CYC_RD_HI   = 9'h1f0;
    localparam logic [8:0] CYC_RD_LO   = 9'h1f1;
    localparam logic [8:0] STATUS_RD   = 9'h1f2;

    // ==========================================================
    // pack option byte fields
    localparam int OPT_SRC     = 7;
    localparam int OPT_LED_HI  = 6;
    localparam int OPT_LED_LO  = 5;
    localparam int OPT_HST_CHK = 4;
    localparam int OPT_CHG_CHK = 3;
    localparam int OPT_BDIS    = 2;
    localparam int OPT_CELL_HI = 1;
    localparam int OPT_CELL_LO = 0;

    // ==========================================================
    // reset values and scaling
    localparam logic [7:0]  MEM_RESET   = 8'h00;
    localparam logic [15:0] CYCLE_RESET = 16'h0000;
    localparam logic [31:0] MWH_DIV     = 32'd10000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [6:0]         abs_soc;
        logic [6:0]         rel_soc;
        logic               mwh_mode;
        logic               alarm_off;
        logic               charger_off;
        logic               host_req;
        logic               chg_req;
        logic               conv_vld;
        logic signed [15:0] conv_raw;
        logic               dsg_vld;
        logic [15:0]        dsg_mah;
        logic               add_vld;
        logic [15:0]        add_mah;
        logic               sleep_req;
        logic [15:0]        cc_ofs;
        logic [7:0]         dsc_ofs;
        logic [7:0]         adc_ofs;
        logic               learn_vld;
        logic [15:0]        learn_fcc;
    } gauge_in_t;

    typedef struct packed {
        logic [6:0]         led_soc;
        logic [2:0]         led_segments;
        logic [2:0]         series_cells;
        logic               host_pec_en;
        logic               chg_pec_en;
        logic               host_bcast_go;
        logic               chg_bcast_go;
        logic [7:0]         filter_thr;
        logic [15:0]        design_cap;
        logic [15:0]        full_cap;
        logic [15:0]        time_alarm;
        logic [15:0]        cap_alarm;
        logic [15:0]        cycle;
        logic signed [31:0] chg_mah;
        logic               chg_vld;
        logic [15:0]        eff_mah;
        logic               eff_vld;
        logic               sleep_go;
        logic               cfg_ready;
    } cfg_out_t;

endpackage

// *** verilog/gauge_pack_config_params.sv ***
// configuration and parameter bank of a battery gas gauge: byte
// storage, pack option decode, charge scaling and cycle counting.
// assumes one clock, synchronous inputs and a bus master that never
// issues read and write together.
//
// Function
// (RQ1) led source: absolute or relative charge
// (RQ2) decode led count field to segments
// (RQ3) host alarm pec byte follows enable
// (RQ4) charger broadcast pec byte follows enable
// (RQ5) broadcast disable stops host/charger broadcasts
// (RQ6) battery mode cannot override broadcast disable
// (RQ7) decode cell count field to series cells
// (RQ8) store offsets before entering sleep
// (RQ9) scale converter result by sense gain
// (RQ10) correct coulomb count by 32-bit gain
// (RQ11) filter threshold from stored byte
// (RQ12) design capacity in mah or 10mwh
// (RQ13) full capacity stored, updated after learning
// (RQ14) stored time and capacity alarm thresholds
// (RQ15) cycle counter loads stored initial value
// (RQ16) count cycle when discharge reaches threshold
// (RQ17) scale added charge by efficiency factor
// (RQ18) programmer writes reserved bytes exactly
// (RQ19) option byte field positions fixed
// (RQ20) latch options after reset and rewrite
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module gauge_pack_config_params
    import gauge_cfg_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst_b,
    input  wire bus_req_t  bus,
    output logic [7:0]     rdata,
    input  wire gauge_in_t gin,
    output cfg_out_t       cfg_out
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] mem;
        logic [7:0]                opt;
        logic                      loaded;
        logic                      opt_dirty;
        logic [7:0]                rdata;
        logic [15:0]               acc;
        logic signed [31:0]        p1;
        logic                      p1_vld;
        cfg_out_t                  out;
    } state_t;

    state_t s;
    state_t next_s;

    // big-endian word from two storage bytes
    function automatic logic [15:0] word16(
        input logic [MEM_DEPTH-1:0][7:0] m,
        input logic [8:0]                a
    );
        return {m[a], m[a + 9'd1]};
    endfunction

    logic [15:0] cyc_thr;
    assign cyc_thr = word16(s.mem, CYCLE_THR);

    // ==========================================================
    // next state
    always_comb begin
        logic [16:0]        acc_sum;
        logic [31:0]        wh;
        logic [31:0]        ccd;
        logic signed [64:0] prod;
        logic [24:0]        effp;
        acc_sum = 17'd0;
        wh      = 32'd0;
        ccd     = 32'd0;
        prod    = 65'sd0;
        effp    = 25'd0;
        next_s  = s;

        // pulses fall back each cycle
        next_s.opt_dirty    = 1'b0;
        next_s.p1_vld       = 1'b0;
        next_s.out.chg_vld  = 1'b0;
        next_s.out.eff_vld  = 1'b0;
        next_s.out.sleep_go = 1'b0;
        next_s.rdata        = 8'h00;

        // register read, answer in the following cycle only
        if (bus.rd) begin
            if (bus.addr < MEM_TOP) begin
                next_s.rdata = s.mem[bus.addr];
            end else if (bus.addr == CYC_RD_HI) begin
                next_s.rdata = s.out.cycle[15:8];
            end else if (bus.addr == CYC_RD_LO) begin
                next_s.rdata = s.out.cycle[7:0];
            end else if (bus.addr == STATUS_RD) begin
                next_s.rdata = {7'h00, s.loaded};
            end
        end

        // register write; addresses past storage are dropped
        if (bus.wr && bus.addr < MEM_TOP) begin
            next_s.mem[bus.addr] = bus.wdata;
            next_s.opt_dirty     = (bus.addr == PACK_OPT); // [RQ20]
        end

        // learned capacity replaces the stored start value
        if (gin.learn_vld) begin
            next_s.mem[FULL_CAP]        = gin.learn_fcc[15:8]; // [RQ13]
            next_s.mem[FULL_CAP + 9'd1] = gin.learn_fcc[7:0];
        end

        // offsets refreshed on the way into sleep; this hardware
        // update wins over a bus write in the same cycle
        if (gin.sleep_req) begin
            next_s.mem[CC_OFS]        = gin.cc_ofs[15:8]; // [RQ8]
            next_s.mem[CC_OFS + 9'd1] = gin.cc_ofs[7:0];
            next_s.mem[DSC_OFS]       = gin.dsc_ofs;
            next_s.mem[ADC_OFS]       = gin.adc_ofs;
        end
        next_s.out.sleep_go = gin.sleep_req; // [RQ8]

        // options latched once after reset and on each rewrite
        next_s.loaded        = 1'b1;
        next_s.out.cfg_ready = s.loaded;
        if (!s.loaded || s.opt_dirty) begin
            next_s.opt = s.mem[PACK_OPT]; // [RQ20]
        end

        // ======================================================
        // option decode, from the latched copy only
        next_s.out.led_soc = s.opt[OPT_SRC] ? gin.rel_soc // [RQ1]
                                            : gin.abs_soc;
        unique case ({s.opt[OPT_LED_HI], s.opt[OPT_LED_LO]}) // [RQ19]
            2'b00: next_s.out.led_segments = 3'd5; // [RQ2]
            2'b01: next_s.out.led_segments = 3'd3;
            2'b10: next_s.out.led_segments = 3'd4;
            2'b11: next_s.out.led_segments = 3'd5;
        endcase
        // code 00 is undefined for cells; report zero so it shows
        unique case ({s.opt[OPT_CELL_HI], s.opt[OPT_CELL_LO]})
            2'b11: next_s.out.series_cells = 3'd4; // [RQ7]
            2'b10: next_s.out.series_cells = 3'd3;
            2'b01: next_s.out.series_cells = 3'd2;
            2'b00: next_s.out.series_cells = 3'd0;
        endcase
        next_s.out.host_pec_en = s.opt[OPT_HST_CHK]; // [RQ3]
        next_s.out.chg_pec_en  = s.opt[OPT_CHG_CHK]; // [RQ4]

        // broadcast gate: the option bit sits after the mode bits,
        // so no mode setting can reopen it
        next_s.out.host_bcast_go = gin.host_req & ~gin.alarm_off
                                 & ~s.opt[OPT_BDIS] & s.loaded; // [RQ5]
        next_s.out.chg_bcast_go  = gin.chg_req & ~gin.charger_off
                                 & ~s.opt[OPT_BDIS] & s.loaded; // [RQ6]

        // ======================================================
        // stored parameters presented to the gauge core
        next_s.out.filter_thr = s.mem[FILTER_THR]; // [RQ11]
        next_s.out.full_cap   = word16(s.mem, FULL_CAP); // [RQ13]
        next_s.out.time_alarm = word16(s.mem, TIME_ALARM); // [RQ14]
        next_s.out.cap_alarm  = word16(s.mem, CAP_ALARM); // [RQ14]
        // mah times mv gives uwh; one 10 mwh step is 10000 uwh
        wh = word16(s.mem, DESIGN_CAP) * word16(s.mem, DESIGN_VOLT);
        if (gin.mwh_mode) begin
            next_s.out.design_cap = 16'(wh / MWH_DIV); // [RQ12]
        end else begin
            next_s.out.design_cap = word16(s.mem, DESIGN_CAP);
        end

        // ======================================================
        // cycle counting; initial value taken on the first cycle
        if (!s.loaded) begin
            next_s.out.cycle = word16(s.mem, CYCLE_INIT); // [RQ15]
            next_s.acc       = 16'h0000;
        end else if (gin.dsg_vld && cyc_thr != 16'h0000) begin
            acc_sum = {1'b0, s.acc} + {1'b0, gin.dsg_mah};
            if (acc_sum >= {1'b0, cyc_thr}) begin
                acc_sum          = acc_sum - {1'b0, cyc_thr};
                next_s.out.cycle = s.out.cycle + 16'd1; // [RQ16]
            end
            next_s.acc = acc_sum[15:0];
        end

        // ======================================================
        // two-stage charge scaling: gain first, then correction
        next_s.p1     = gin.conv_raw
                      * $signed({1'b0, word16(s.mem, SENSE_GAIN)}); // [RQ9]
        next_s.p1_vld = gin.conv_vld;
        ccd  = {word16(s.mem, CC_DELTA),
                word16(s.mem, CC_DELTA + 9'd2)};
        prod = s.p1 * $signed({1'b0, ccd});
        if (s.p1_vld) begin
            next_s.out.chg_mah = prod[63:32]; // [RQ10]
            next_s.out.chg_vld = 1'b1;
        end

        // efficiency: stored byte is pct*2.56-1, so add one back
        effp = gin.add_mah * ({1'b0, s.mem[CHG_EFF]} + 9'd1);
        if (gin.add_vld) begin
            next_s.out.eff_mah = effp[23:8]; // [RQ17]
            next_s.out.eff_vld = 1'b1;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s                  <= '0;
            s.mem              <= {MEM_DEPTH{MEM_RESET}};
            s.out.cycle        <= CYCLE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rdata   = s.rdata;
    assign cfg_out = s.out;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence seq_opt_wr;
        bus.wr && bus.addr == PACK_OPT;
    endsequence

    sequence seq_sleep;
        gin.sleep_req ##1 s.out.sleep_go;
    endsequence

    sequence seq_conv;
        gin.conv_vld ##1 s.p1_vld ##1 s.out.chg_vld;
    endsequence

    chk_led_rel: assert property ( // [RQ1]
        s.opt[OPT_SRC] |=> s.out.led_soc == $past(gin.rel_soc))
        else $error("led source not relative charge");

    chk_led_abs: assert property ( // [RQ1]
        s.loaded && !s.opt[OPT_SRC]
        |=> s.out.led_soc == $past(gin.abs_soc))
        else $error("led source not absolute charge");

    chk_led_three: assert property ( // [RQ2]
        s.opt[OPT_LED_HI:OPT_LED_LO] == 2'b01
        |=> s.out.led_segments == 3'd3)
        else $error("led count 01 not three");

    chk_host_pec: assert property ( // [RQ3]
        s.opt[OPT_HST_CHK] |=> s.out.host_pec_en)
        else $error("host pec enable lost");

    chk_chg_pec: assert property ( // [RQ4]
        !s.opt[OPT_CHG_CHK] |=> !s.out.chg_pec_en)
        else $error("charger pec sent while off");

    chk_bcast_block: assert property ( // [RQ6]
        s.opt[OPT_BDIS]
        |=> !s.out.host_bcast_go && !s.out.chg_bcast_go)
        else $error("broadcast while disabled");

    chk_bcast_pass: assert property ( // [RQ5]
        s.loaded && !s.opt[OPT_BDIS] && gin.chg_req
        && !gin.charger_off |=> s.out.chg_bcast_go)
        else $error("enabled broadcast dropped");

    chk_cell_three: assert property ( // [RQ7]
        s.opt[OPT_CELL_HI:OPT_CELL_LO] == 2'b10
        |=> s.out.series_cells == 3'd3)
        else $error("cell code 10 not three");

    chk_sleep_store: assert property ( // [RQ8]
        seq_sleep |-> s.mem[DSC_OFS] == $past(gin.dsc_ofs)
                   && s.mem[ADC_OFS] == $past(gin.adc_ofs))
        else $error("offsets not stored before sleep");

    chk_conv_path: assert property ( // [RQ10]
        gin.conv_vld |-> seq_conv)
        else $error("charge result latency wrong");

    chk_cycle_inc: assert property ( // [RQ16]
        s.loaded && gin.dsg_vld && cyc_thr == 16'd1
        && gin.dsg_mah != 16'h0000
        |=> s.out.cycle == $past(s.out.cycle) + 16'd1)
        else $error("cycle count not advanced");

    chk_eff_unity: assert property ( // [RQ17]
        gin.add_vld && s.mem[CHG_EFF] == 8'hff
        |=> s.out.eff_vld && s.out.eff_mah == $past(gin.add_mah))
        else $error("full efficiency changed charge");

    chk_opt_relatch: assert property ( // [RQ20]
        seq_opt_wr |-> ##2 s.opt == $past(bus.wdata, 2))
        else $error("option byte not relatched");

    // ==========================================================
    // decode and stored values; the load flag keeps the reset
    // edge itself from starting an attempt that must fail
    chk_led_four: assert property ( // [RQ2]
        s.loaded && s.opt[OPT_LED_HI:OPT_LED_LO] == 2'b10
        |=> s.out.led_segments == 3'd4)
        else $error("led count 10 not four");

    chk_led_five: assert property ( // [RQ2]
        s.loaded && s.opt[OPT_LED_HI] == s.opt[OPT_LED_LO]
        |=> s.out.led_segments == 3'd5)
        else $error("led count 00 or 11 not five");

    chk_cell_four: assert property ( // [RQ7]
        s.loaded && s.opt[OPT_CELL_HI:OPT_CELL_LO] == 2'b11
        |=> s.out.series_cells == 3'd4)
        else $error("cell code 11 not four");

    chk_cell_two: assert property ( // [RQ7]
        s.loaded && s.opt[OPT_CELL_HI:OPT_CELL_LO] == 2'b01
        |=> s.out.series_cells == 3'd2)
        else $error("cell code 01 not two");

    chk_host_nopec: assert property ( // [RQ3]
        !s.opt[OPT_HST_CHK] |=> !s.out.host_pec_en)
        else $error("host pec sent while off");

    chk_chg_pecon: assert property ( // [RQ4]
        s.opt[OPT_CHG_CHK] |=> s.out.chg_pec_en)
        else $error("charger pec enable lost");

    chk_host_pass: assert property ( // [RQ5]
        s.loaded && !s.opt[OPT_BDIS] && gin.host_req
        && !gin.alarm_off |=> s.out.host_bcast_go)
        else $error("enabled host broadcast dropped");

    chk_no_early: assert property ( // [RQ20]
        !s.loaded |=> !s.out.host_bcast_go && !s.out.chg_bcast_go)
        else $error("broadcast before options latched");

    chk_opt_first: assert property ( // [RQ20]
        !s.loaded |=> s.opt == $past(s.mem[PACK_OPT]))
        else $error("option byte not latched after reset");

    chk_cycle_load: assert property ( // [RQ15]
        !s.loaded |=> s.out.cycle == {$past(s.mem[CYCLE_INIT]),
                                      $past(s.mem[CYCLE_INIT + 9'd1])})
        else $error("cycle count not loaded from storage");

    chk_filter_thr: assert property ( // [RQ11]
        s.loaded |=> s.out.filter_thr == $past(s.mem[FILTER_THR]))
        else $error("filter threshold not from storage");

    chk_cap_mah: assert property ( // [RQ12]
        s.loaded && !gin.mwh_mode
        |=> s.out.design_cap == {$past(s.mem[DESIGN_CAP]),
                                 $past(s.mem[DESIGN_CAP + 9'd1])})
        else $error("design capacity changed in mah mode");

    chk_time_alarm: assert property ( // [RQ14]
        s.loaded |=> s.out.time_alarm == {$past(s.mem[TIME_ALARM]),
                                          $past(s.mem[TIME_ALARM + 9'd1])})
        else $error("time alarm not from storage");

    chk_full_learn: assert property ( // [RQ13]
        gin.learn_vld |=> {s.mem[FULL_CAP], s.mem[FULL_CAP + 9'd1]}
                          == $past(gin.learn_fcc))
        else $error("learned capacity not stored");

endmodule

// *** dv/bcast_listener.sv ***
// far-side model: host and charger counting offered broadcasts.
// assumes each go level is one broadcast offer per mclk cycle.
`timescale 1ns/1ns
module bcast_listener (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       host_go,
    input  wire logic       chg_go,
    output logic      [7:0] host_cnt,
    output logic      [7:0] chg_cnt
);
    // ==========================================================
    // offer counters; an offer while broadcasts are off shows up
    // as a count that the bench did not plan for
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            host_cnt <= 8'h00;
            chg_cnt  <= 8'h00;
        end else begin
            host_cnt <= host_cnt + {7'h00, host_go};
            chg_cnt  <= chg_cnt + {7'h00, chg_go};
        end
    end
endmodule

// *** dv/gauge_pack_config_params_tb.sv ***
// bench for the gauge configuration bank: bus tasks and sequences.
// assumes the bus never stalls and storage is cleared by reset.
`timescale 1ns/1ns
module gauge_pack_config_params_tb import gauge_cfg_pkg::*;;
    logic       mclk;
    logic       rst_b;
    bus_req_t   bus_q;
    logic [7:0] rdata;
    gauge_in_t  gin_q;
    cfg_out_t   cfg_out;
    logic [7:0] host_cnt;
    logic [7:0] chg_cnt;
    logic [7:0] rd_v;
    logic [1:0] lc;
    int         n_mismatch;
    int         n_compared;
    int         cyc_cnt;
    logic [2:0] seg_exp [4] = '{3'h5, 3'h3, 3'h4, 3'h5};
    logic [2:0] cell_exp [4] = '{3'h0, 3'h2, 3'h3, 3'h4};

    gauge_pack_config_params DUT (.mclk(mclk), .rst_b(rst_b), .bus(bus_q),
        .rdata(rdata), .gin(gin_q), .cfg_out(cfg_out));
    bcast_listener far_side (.mclk(mclk), .rst_b(rst_b),
        .host_go(cfg_out.host_bcast_go), .chg_go(cfg_out.chg_bcast_go),
        .host_cnt(host_cnt), .chg_cnt(chg_cnt));

    // ==========================================================
    // reporting
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // bus master tasks
    task wr8(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_q.wr    <= 1'b1;
        bus_q.addr  <= a;
        bus_q.wdata <= d;
        @(posedge mclk);
        bus_q.wr    <= 1'b0;
    endtask

    // big-endian pair, high byte at the lower address
    task wr16(input logic [8:0] a, input logic [15:0] d);
        wr8(a, d[15:8]);
        wr8(a + 9'h001, d[7:0]);
    endtask

    // read data stand only in the cycle after the strobe
    task rd8(input logic [8:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_q.rd   <= 1'b1;
        bus_q.addr <= a;
        @(posedge mclk);
        bus_q.rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // write lands, option latch, then decode: three edges plus one
    task settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // offer broadcasts for four cycles, battery mode bits dropped
    task bcast(input logic [7:0] opt, input logic [7:0] exp);
        logic [7:0] h0;
        logic [7:0] c0;
        wr8(PACK_OPT, opt);
        settle();
        h0 = host_cnt;
        c0 = chg_cnt;
        @(posedge mclk);
        gin_q.host_req    <= 1'b1;
        gin_q.chg_req     <= 1'b1;
        gin_q.alarm_off   <= 1'b0;
        gin_q.charger_off <= 1'b0;
        repeat (4) @(posedge mclk);
        gin_q.host_req <= 1'b0;
        gin_q.chg_req  <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check(host_cnt - h0, exp);
        check(chg_cnt - c0, exp);
    endtask

    // ==========================================================
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        cyc_cnt = 0;
        rst_b = 1'b0;
        bus_q = '0;
        gin_q = '0;
        gin_q.abs_soc = 7'h11;
        gin_q.rel_soc = 7'h22;
        gin_q.conv_raw = 16'sh0064;
        gin_q.dsg_mah = 16'h003c;
        gin_q.add_mah = 16'h03e8;
        gin_q.cc_ofs = 16'hc225;
        gin_q.dsc_ofs = 8'h26;
        gin_q.adc_ofs = 8'h27;
        gin_q.learn_fcc = 16'h1234;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        settle();
        check(cfg_out.cfg_ready, 1'b1);
        check(cfg_out.cycle, 16'h0000);
        rd8(STATUS_RD, rd_v);
        check(rd_v[0], 1'b1);
        // every led and cell code, pec and source bits toggled
        for (int i = 0; i < 4; i++) begin
            lc = i[1:0];
            wr8(PACK_OPT, {lc[0], lc, lc[0], lc[1], 1'b0, lc});
            settle();
            check(cfg_out.led_segments, seg_exp[i]);
            check(cfg_out.series_cells, cell_exp[i]);
            check(cfg_out.host_pec_en, lc[0]);
            check(cfg_out.chg_pec_en, lc[1]);
            check(cfg_out.led_soc, lc[0] ? 7'h22 : 7'h11);
        end
        bcast(8'h00, 8'h04);
        gin_q.alarm_off <= 1'b1;
        gin_q.charger_off <= 1'b1;
        bcast(8'h04, 8'h00);
        // storage contents written as a programmer would
        wr8(FILTER_THR, 8'h5a);
        wr8(MEM_TOP, 8'h77);
        settle();
        check(cfg_out.filter_thr, 8'h5a);
        rd8(FILTER_THR, rd_v);
        check(rd_v, 8'h5a);
        rd8(MEM_TOP, rd_v);
        check(rd_v, 8'h00);
        wr16(DESIGN_CAP, 16'h0bb8);
        wr16(DESIGN_VOLT, 16'h2ee0);
        wr16(CAP_ALARM, 16'h012c);
        wr16(TIME_ALARM, 16'h000a);
        settle();
        check(cfg_out.design_cap, 16'h0bb8);
        check(cfg_out.cap_alarm, 16'h012c);
        check(cfg_out.time_alarm, 16'h000a);
        gin_q.mwh_mode <= 1'b1;
        settle();
        check(cfg_out.design_cap, 16'h0e10);
        wr16(FULL_CAP, 16'h1130);
        settle();
        check(cfg_out.full_cap, 16'h1130);
        gin_q.learn_vld <= 1'b1;
        @(posedge mclk);
        gin_q.learn_vld <= 1'b0;
        settle();
        check(cfg_out.full_cap, 16'h1234);
        // threshold 100 mAh, two removals of 60 mAh make one cycle
        wr16(CYCLE_THR, 16'h0064);
        settle();
        repeat (2) begin
            @(posedge mclk);
            gin_q.dsg_vld <= 1'b1;
            @(posedge mclk);
            gin_q.dsg_vld <= 1'b0;
        end
        settle();
        check(cfg_out.cycle, 16'h0001);
        rd8(CYC_RD_LO, rd_v);
        check(rd_v, 8'h01);
        // threshold of one: a single removal counts once more
        wr16(CYCLE_THR, 16'h0001);
        settle();
        gin_q.dsg_vld <= 1'b1;
        @(posedge mclk);
        gin_q.dsg_vld <= 1'b0;
        settle();
        check(cfg_out.cycle, 16'h0002);
        // 0xf2 is 95 percent: 1000 mAh in gives 949
        wr8(CHG_EFF, 8'hf2);
        settle();
        gin_q.add_vld <= 1'b1;
        @(posedge mclk);
        gin_q.add_vld <= 1'b0;
        #1;
        check(cfg_out.eff_vld, 1'b1);
        check(cfg_out.eff_mah, 16'h03b5);
        // 0xff is full efficiency: charge passes unchanged
        wr8(CHG_EFF, 8'hff);
        settle();
        gin_q.add_vld <= 1'b1;
        @(posedge mclk);
        gin_q.add_vld <= 1'b0;
        #1;
        check(cfg_out.eff_mah, 16'h03e8);
        // gain 15312 and half-scale correction on a count of 100
        wr16(SENSE_GAIN, 16'h3bd0);
        wr16(CC_DELTA, 16'h8000);
        wr16(9'h0cf, 16'h0000);
        settle();
        gin_q.conv_vld <= 1'b1;
        @(posedge mclk);
        gin_q.conv_vld <= 1'b0;
        @(posedge mclk);
        #1;
        check(cfg_out.chg_vld, 1'b1);
        check(cfg_out.chg_mah, 32'h000baea0);
        gin_q.sleep_req <= 1'b1;
        @(posedge mclk);
        gin_q.sleep_req <= 1'b0;
        #1;
        check(cfg_out.sleep_go, 1'b1);
        rd8(CC_OFS, rd_v);
        check(rd_v, 8'hc2);
        rd8(CC_OFS + 9'h001, rd_v);
        check(rd_v, 8'h25);
        rd8(DSC_OFS, rd_v);
        check(rd_v, 8'h26);
        rd8(ADC_OFS, rd_v);
        check(rd_v, 8'h27);
        close_out();
    end
endmodule
